// *** hw/tcpc_pkg.sv ***
// constants and types for the capture and pulse-compare block
package tcpc_pkg;
  // -----------------------------------------------------------
  // register byte offsets (low address byte)
  // -----------------------------------------------------------
  localparam logic [7:0] OFF_CAP_CTRL = 8'h00; // capture_channel_control
  localparam logic [7:0] OFF_CAP_FIFO = 8'h04; // capture fifo pop port
  localparam logic [7:0] OFF_CMP_CTRL = 8'h08; // compare_channel_control
  localparam logic [7:0] OFF_CMP_PRI = 8'h0c; // primary_compare_value
  localparam logic [7:0] OFF_CMP_SEC = 8'h10; // secondary_compare_value
  localparam logic [7:0] OFF_IRQ = 8'h14; // irq flags and enable
  localparam logic [7:0] OFF_TB_CTRL = 8'h18; // timebase_control, base a
  localparam logic [7:0] OFF_TB_CNT = 8'h1c; // timebase_count, base a
  localparam logic [7:0] OFF_TB_PER = 8'h20; // timebase_period, base a
  localparam logic [7:0] TB_STRIDE = 8'h0c; // base b follows base a
  // -----------------------------------------------------------
  // field positions
  // -----------------------------------------------------------
  localparam int CAP_IDLE_BIT = 13; // capture_idle_halt
  localparam int CAP_TSEL_BIT = 7; // capture_timebase_select
  localparam int CAP_ICI_LSB = 5; // captures_per_irq, 2 bits
  localparam int CAP_OV_BIT = 4; // capture_overrun_flag
  localparam int CAP_BNE_BIT = 3; // capture_fifo_not_empty
  localparam int CMP_TSEL_BIT = 3; // compare_timebase_select
  localparam int TB_RUN_BIT = 15; // timebase_run
  localparam int TB_EXT_BIT = 1; // external tick select
  localparam int IRQ_CMP_FLAG_BIT = 0; // compare_irq_flag
  localparam int IRQ_CMP_EN_BIT = 1; // compare_irq_enable
  localparam int IRQ_CAP_FLAG_BIT = 2; // capture irq flag
  // -----------------------------------------------------------
  // modes, counts, reset values
  // -----------------------------------------------------------
  localparam logic [2:0] CAP_ANY = 3'h1; // every edge
  localparam logic [2:0] CAP_FALL = 3'h2; // every falling edge
  localparam logic [2:0] CAP_RISE = 3'h3; // every rising edge
  localparam logic [2:0] CAP_RISE4 = 3'h4; // every 4th rising edge
  localparam logic [2:0] CAP_RISE16 = 3'h5; // every 16th rising edge
  localparam logic [2:0] CAP_WAKE = 3'h7; // rising edge wake only
  localparam logic [2:0] CMP_SINGLE = 3'h4; // one pulse
  localparam logic [2:0] CMP_CONT = 3'h5; // continuous pulses
  localparam logic [3:0] PRE4_LAST = 4'h3; // last count of 4
  localparam logic [3:0] PRE16_LAST = 4'hf; // last count of 16
  localparam logic [2:0] FIFO_DEPTH = 3'h4; // capture words held
  localparam logic [15:0] TB_PER_RST = 16'hffff; // period at reset
  localparam logic [15:0] TB_ZERO = 16'h0000; // count after wrap
  // compare sequencer states
  typedef enum logic [1:0] {CMP_OFF, CMP_WAIT_RISE, CMP_WAIT_FALL, CMP_DONE} cmp_state_t;
endpackage : tcpc_pkg

// *** hw/timer_capture_and_pulse_compare.sv ***
// timebases, capture channel with fifo, pulse compare channel, ahb-lite slave
// What this block does
// - capture stores full 16-bit selected count
// - simple modes: falling, rising, or any edge
// - prescaled mode captures every 4th rise
// - prescaled mode captures every 16th rise
// - select bit picks one of two timebases
// - captures queue in four-word fifo
// - irq after one to four captures
// - capture pin event wakes from sleep/idle
// - single-pulse write forces pin low, arms
// - continuous write forces low, pulses repeatedly
// - pin high on primary match
// - pin low on secondary match
// - single pulse then stays low
// - trailing edge sets flag; enable gates irq
// - rewriting single code re-arms channel
// - compare select bit picks timebase
// - count wraps to zero at period
// - continuous: every secondary match that ends a pulse sets flag
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module timer_capture_and_pulse_compare
  import tcpc_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic capture_input_pin_in,
  input wire logic cpu_idle_in,
  input wire logic cpu_sleep_in,
  input wire logic [1:0] tb_ext_tick_in,
  output logic compare_output_pin_out,
  output logic capture_irq_out,
  output logic compare_irq_out,
  output logic wake_out
);
  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  // register offset of timebase i
  function automatic logic [7:0] tb_off(input logic [7:0] base, input int i);
    tb_off = base + (i == 1 ? TB_STRIDE : 8'h00);
  endfunction : tb_off

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  logic ap_valid_reg; // data phase pending
  logic ap_write_reg; // pending is a write
  logic [7:0] ap_addr_reg; // pending address
  logic [15:0] tb_cnt_reg [2]; // timebase_count
  logic [15:0] tb_per_reg [2]; // timebase_period
  logic [1:0] tb_run_reg; // timebase_run
  logic [1:0] tb_ext_reg; // count external ticks
  logic cap_idle_reg; // capture_idle_halt
  logic cap_tsel_reg; // capture_timebase_select
  logic [1:0] cap_ici_reg; // captures_per_irq
  logic [2:0] cap_mode_reg; // capture_mode_select
  logic cap_ov_reg; // capture_overrun_flag
  logic cap_flag_reg; // capture irq flag
  logic pin_prev_reg; // previous pin level
  logic [3:0] pre_reg; // rising edge prescaler
  logic [1:0] seen_reg; // captures since last irq
  logic [15:0] fifo_mem [4]; // capture words
  logic [1:0] wptr_reg; // fifo write pointer
  logic [1:0] rptr_reg; // fifo read pointer
  logic [2:0] fifo_cnt_reg; // words held
  logic cmp_tsel_reg; // compare_timebase_select
  logic [2:0] cmp_mode_reg; // compare_mode_select
  logic [15:0] cmp_pri_reg; // primary_compare_value
  logic [15:0] cmp_sec_reg; // secondary_compare_value
  logic cmp_flag_reg; // compare_irq_flag
  logic cmp_en_reg; // compare_irq_enable
  cmp_state_t cmp_state_reg; // pulse sequencer
  logic [31:0] rd_mux; // read data next

  // bus decode
  logic take, rd_fire, wr_fire;
  assign take = hsel_in & hready_in & htrans_in[1];
  assign rd_fire = ap_valid_reg & ~ap_write_reg & ~hreadyout_out;
  assign wr_fire = ap_valid_reg & ap_write_reg;
  logic wr_cap, wr_cmp, wr_irq;
  assign wr_cap = wr_fire && ap_addr_reg == OFF_CAP_CTRL;
  assign wr_cmp = wr_fire && ap_addr_reg == OFF_CMP_CTRL;
  assign wr_irq = wr_fire && ap_addr_reg == OFF_IRQ;

  // ---------------------------------------------------------
  // ahb-lite slave: writes zero-wait, reads one wait state
  // ---------------------------------------------------------
  // address phase capture
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else if (take) begin
      ap_valid_reg <= 1'b1;
      ap_write_reg <= hwrite_in;
      ap_addr_reg <= haddr_in[7:0];
    end else if (hready_in) begin
      ap_valid_reg <= 1'b0;
    end
  end

  // read wait state and data; read sees state after any prior write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= ~(take & ~hwrite_in);
      hresp_out <= 1'b0; // always okay
      if (rd_fire) begin
        hrdata_out <= rd_mux;
      end
    end
  end

  // read multiplexer; unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ap_addr_reg)
      OFF_CAP_CTRL: begin
        rd_mux[CAP_IDLE_BIT] = cap_idle_reg;
        rd_mux[CAP_TSEL_BIT] = cap_tsel_reg;
        rd_mux[CAP_ICI_LSB+:2] = cap_ici_reg;
        rd_mux[CAP_OV_BIT] = cap_ov_reg;
        rd_mux[CAP_BNE_BIT] = fifo_cnt_reg != 3'h0;
        rd_mux[2:0] = cap_mode_reg;
      end
      OFF_CAP_FIFO: rd_mux[15:0] = fifo_mem[rptr_reg];
      OFF_CMP_CTRL: begin
        rd_mux[CMP_TSEL_BIT] = cmp_tsel_reg;
        rd_mux[2:0] = cmp_mode_reg;
      end
      OFF_CMP_PRI: rd_mux[15:0] = cmp_pri_reg;
      OFF_CMP_SEC: rd_mux[15:0] = cmp_sec_reg;
      OFF_IRQ: begin
        rd_mux[IRQ_CMP_FLAG_BIT] = cmp_flag_reg;
        rd_mux[IRQ_CMP_EN_BIT] = cmp_en_reg;
        rd_mux[IRQ_CAP_FLAG_BIT] = cap_flag_reg;
      end
      default: begin
        for (int i = 0; i < 2; i++) begin
          if (ap_addr_reg == tb_off(OFF_TB_CTRL, i)) begin
            rd_mux[TB_RUN_BIT] = tb_run_reg[i];
            rd_mux[TB_EXT_BIT] = tb_ext_reg[i];
          end
          if (ap_addr_reg == tb_off(OFF_TB_CNT, i)) rd_mux[15:0] = tb_cnt_reg[i];
          if (ap_addr_reg == tb_off(OFF_TB_PER, i)) rd_mux[15:0] = tb_per_reg[i];
        end
      end
    endcase
  end

  // ---------------------------------------------------------
  // two timebases
  // ---------------------------------------------------------
  // count, wrap at period, software writes
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 2; i++) begin
        tb_cnt_reg[i] <= TB_ZERO;
        tb_per_reg[i] <= TB_PER_RST;
      end
      tb_run_reg <= 2'b00;
      tb_ext_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_fire && ap_addr_reg == tb_off(OFF_TB_CTRL, i)) begin
          tb_run_reg[i] <= hwdata_in[TB_RUN_BIT];
          tb_ext_reg[i] <= hwdata_in[TB_EXT_BIT];
        end
        if (wr_fire && ap_addr_reg == tb_off(OFF_TB_PER, i)) begin
          tb_per_reg[i] <= hwdata_in[15:0];
        end
        // internal clock or external tick
        if (wr_fire && ap_addr_reg == tb_off(OFF_TB_CNT, i)) begin
          tb_cnt_reg[i] <= hwdata_in[15:0];
        end else if (tb_run_reg[i] && (!tb_ext_reg[i] || tb_ext_tick_in[i])) begin
          tb_cnt_reg[i] <= (tb_cnt_reg[i] == tb_per_reg[i]) ? TB_ZERO
                           : 16'(tb_cnt_reg[i] + 16'h0001);
        end
      end
    end
  end

  // ---------------------------------------------------------
  // capture channel
  // ---------------------------------------------------------
  logic rise, fall, halted, cap_evt, full, push, pop;
  logic [15:0] cap_cnt, cmp_cnt;
  assign rise = capture_input_pin_in & ~pin_prev_reg;
  assign fall = ~capture_input_pin_in & pin_prev_reg;
  assign halted = cpu_idle_in & cap_idle_reg;
  assign cap_cnt = tb_cnt_reg[cap_tsel_reg];
  assign cmp_cnt = tb_cnt_reg[cmp_tsel_reg];
  assign full = fifo_cnt_reg == FIFO_DEPTH;
  assign push = cap_evt & ~full;
  assign pop = rd_fire && ap_addr_reg == OFF_CAP_FIFO && fifo_cnt_reg != 3'h0;

  // capture event by mode
  always_comb begin
    unique case (cap_mode_reg)
      CAP_ANY: cap_evt = rise | fall;
      CAP_FALL: cap_evt = fall;
      CAP_RISE: cap_evt = rise;
      CAP_RISE4: cap_evt = rise && pre_reg == PRE4_LAST;
      CAP_RISE16: cap_evt = rise && pre_reg == PRE16_LAST;
      default: cap_evt = 1'b0; // off, unused, wake only
    endcase
    if (halted) cap_evt = 1'b0;
  end

  // control fields, edge history, prescaler, irq grouping
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_idle_reg <= 1'b0;
      cap_tsel_reg <= 1'b0;
      cap_ici_reg <= 2'b00;
      cap_mode_reg <= 3'h0;
      pin_prev_reg <= 1'b0;
      pre_reg <= 4'h0;
      seen_reg <= 2'b00;
    end else begin
      pin_prev_reg <= capture_input_pin_in;
      if (wr_cap) begin
        cap_idle_reg <= hwdata_in[CAP_IDLE_BIT];
        cap_tsel_reg <= hwdata_in[CAP_TSEL_BIT];
        cap_ici_reg <= hwdata_in[CAP_ICI_LSB+:2];
        cap_mode_reg <= hwdata_in[2:0];
        pre_reg <= 4'h0;
        seen_reg <= 2'b00;
      end else begin
        // prescaler counts rises, restarts at capture
        if (rise && !halted && (cap_mode_reg == CAP_RISE4 || cap_mode_reg == CAP_RISE16)) begin
          pre_reg <= cap_evt ? 4'h0 : 4'(pre_reg + 4'h1);
        end
        if (push) begin
          seen_reg <= (cap_mode_reg == CAP_ANY || seen_reg == cap_ici_reg) ? 2'b00
                      : 2'(seen_reg + 2'b01);
        end
      end
    end
  end

  // fifo storage
  always_ff @(posedge clk_in) begin
    if (push) fifo_mem[wptr_reg] <= cap_cnt;
  end

  // fifo pointers and fill count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr_reg <= 2'b00;
      rptr_reg <= 2'b00;
      fifo_cnt_reg <= 3'h0;
    end else begin
      if (push) wptr_reg <= 2'(wptr_reg + 2'b01);
      if (pop) rptr_reg <= 2'(rptr_reg + 2'b01);
      if (push && !pop) fifo_cnt_reg <= 3'(fifo_cnt_reg + 3'h1);
      else if (pop && !push) fifo_cnt_reg <= 3'(fifo_cnt_reg - 3'h1);
    end
  end

  // overrun set on lost capture, cleared by a pop; set wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_ov_reg <= 1'b0;
    end else if (cap_evt && full) begin
      cap_ov_reg <= 1'b1;
    end else if (pop) begin
      cap_ov_reg <= 1'b0;
    end
  end

  // capture irq flag, write one to clear, set wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_flag_reg <= 1'b0;
    end else if (push && !wr_cap && (cap_mode_reg == CAP_ANY || seen_reg == cap_ici_reg)) begin
      cap_flag_reg <= 1'b1;
    end else if (wr_irq && hwdata_in[IRQ_CAP_FLAG_BIT]) begin
      cap_flag_reg <= 1'b0;
    end
  end

  // wake request while asleep or idle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= (cpu_sleep_in | cpu_idle_in)
                  & ((cap_mode_reg == CAP_WAKE & rise) | cap_evt);
    end
  end

  // ---------------------------------------------------------
  // pulse compare channel
  // ---------------------------------------------------------
  logic cmp_hit; // trailing edge this cycle
  assign cmp_hit = !wr_cmp && cmp_state_reg == CMP_WAIT_FALL && cmp_cnt == cmp_sec_reg;

  // value registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_pri_reg <= 16'h0000;
      cmp_sec_reg <= 16'h0000;
      cmp_tsel_reg <= 1'b0;
      cmp_mode_reg <= 3'h0;
    end else begin
      if (wr_fire && ap_addr_reg == OFF_CMP_PRI) cmp_pri_reg <= hwdata_in[15:0];
      if (wr_fire && ap_addr_reg == OFF_CMP_SEC) cmp_sec_reg <= hwdata_in[15:0];
      if (wr_cmp) begin
        cmp_tsel_reg <= hwdata_in[CMP_TSEL_BIT];
        cmp_mode_reg <= hwdata_in[2:0];
      end
    end
  end

  // sequencer; a single or continuous mode write re-arms from any state, timer untouched
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_state_reg <= CMP_OFF;
      compare_output_pin_out <= 1'b0;
    end else if (wr_cmp) begin
      compare_output_pin_out <= 1'b0;
      cmp_state_reg <= (hwdata_in[2:0] == CMP_SINGLE || hwdata_in[2:0] == CMP_CONT)
                       ? CMP_WAIT_RISE : CMP_OFF;
    end else begin
      unique case (cmp_state_reg)
        CMP_WAIT_RISE: begin
          if (cmp_cnt == cmp_pri_reg) begin
            compare_output_pin_out <= 1'b1;
            cmp_state_reg <= CMP_WAIT_FALL;
          end
        end
        CMP_WAIT_FALL: begin
          if (cmp_hit) begin
            compare_output_pin_out <= 1'b0;
            cmp_state_reg <= (cmp_mode_reg == CMP_CONT) ? CMP_WAIT_RISE
                             : CMP_DONE;
          end
        end
        CMP_OFF, CMP_DONE: ; // held low
      endcase
    end
  end

  // compare flag and enable; set wins over clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_flag_reg <= 1'b0;
      cmp_en_reg <= 1'b0;
    end else begin
      if (wr_irq) cmp_en_reg <= hwdata_in[IRQ_CMP_EN_BIT];
      if (cmp_hit) cmp_flag_reg <= 1'b1;
      else if (wr_irq && hwdata_in[IRQ_CMP_FLAG_BIT]) cmp_flag_reg <= 1'b0;
    end
  end

  // interrupt outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      compare_irq_out <= 1'b0;
      capture_irq_out <= 1'b0;
    end else begin
      compare_irq_out <= cmp_flag_reg & cmp_en_reg;
      capture_irq_out <= cap_flag_reg;
    end
  end

  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_tb_wrap: assert property (tb_run_reg[0] && !tb_ext_reg[0] && !wr_fire
    && tb_cnt_reg[0] == tb_per_reg[0] |=> tb_cnt_reg[0] == TB_ZERO)
    else $error("timebase did not wrap at period");
  a_cap_stamp: assert property (push && !pop |=> fifo_cnt_reg == $past(fifo_cnt_reg) + 3'h1
    && fifo_mem[$past(wptr_reg)] == $past(tb_cnt_reg[cap_tsel_reg]))
    else $error("capture word not queued");
  a_fall_only: assert property (cap_evt && cap_mode_reg == CAP_FALL |-> fall)
    else $error("falling mode captured wrong edge");
  a_pre_four: assert property (cap_mode_reg == CAP_RISE4
    |-> pre_reg <= PRE4_LAST && (!cap_evt || pre_reg == PRE4_LAST))
    else $error("4th edge prescale wrong");
  a_pre_sixteen: assert property (cap_evt && cap_mode_reg == CAP_RISE16
    |-> pre_reg == PRE16_LAST)
    else $error("16th edge prescale wrong");
  a_any_irq: assert property (push && !wr_cap && cap_mode_reg == CAP_ANY |=> cap_flag_reg)
    else $error("every-edge capture missed irq");
  a_irq_count: assert property ($rose(cap_flag_reg) && $past(cap_mode_reg) != CAP_ANY
    |-> $past(seen_reg) == $past(cap_ici_reg))
    else $error("capture irq at wrong count");
  a_overrun_set: assert property (cap_evt && full |=> cap_ov_reg && fifo_cnt_reg != 3'h0)
    else $error("lost capture not flagged");
  a_wake_req: assert property (cpu_sleep_in && cap_mode_reg == CAP_WAKE && rise |=> wake_out)
    else $error("no wake on capture pin");
  a_idle_halt: assert property (cpu_idle_in && cap_idle_reg |=> $stable(fifo_cnt_reg) || $past(pop))
    else $error("capture ran while halted in idle");
  a_mode_arm: assert property (wr_cmp && hwdata_in[2:0] == CMP_SINGLE
    |=> !compare_output_pin_out && cmp_state_reg == CMP_WAIT_RISE)
    else $error("single pulse write did not arm low");
  a_rise_pri: assert property (!wr_cmp && cmp_state_reg == CMP_WAIT_RISE
    && tb_cnt_reg[cmp_tsel_reg] == cmp_pri_reg |=> compare_output_pin_out)
    else $error("no leading edge on primary match");
  a_fall_sec: assert property (cmp_hit |=> !compare_output_pin_out && cmp_flag_reg)
    else $error("no trailing edge or flag on secondary");
  a_single_hold: assert property (cmp_state_reg == CMP_DONE && !wr_cmp
    |=> !compare_output_pin_out [*2])
    else $error("single pulse output rose again");
  a_cont_repeat: assert property (cmp_hit && cmp_mode_reg == CMP_CONT
    |=> cmp_state_reg == CMP_WAIT_RISE)
    else $error("continuous mode did not re-arm");
  a_irq_gate: assert property (compare_irq_out |-> $past(cmp_flag_reg) && $past(cmp_en_reg))
    else $error("compare irq not gated by enable");

  c_single_pulse: cover property (cmp_hit && cmp_mode_reg == CMP_SINGLE);
  c_cont_two: cover property (cmp_hit && cmp_mode_reg == CMP_CONT ##[1:300] cmp_hit);
  c_fifo_overrun: cover property (cap_evt && full);
  c_cap_irq_four: cover property ($rose(cap_flag_reg) && cap_ici_reg == 2'b11);
endmodule : timer_capture_and_pulse_compare

// *** tb/pin_partner.sv ***
// pins outside the block: capture source and compare pulse meter
`timescale 1ns/1ps
module pin_partner (
  input wire logic clk_in,
  input wire logic cmp_pin_in,
  output logic cap_pin_out,
  output logic [15:0] n_rise_out,
  output logic [15:0] width_out,
  output logic [15:0] gap_out
);
  logic [15:0] cyc = 16'h0; // free cycle count
  logic [15:0] t_rise = 16'h0; // cycle of last rise
  logic last = 1'b0; // pin one cycle ago
  initial begin
    cap_pin_out = 1'b0;
    n_rise_out = 16'h0;
    width_out = 16'h0;
    gap_out = 16'h0;
  end
  // ----------------------------------
  // n edges, gap cycles apart, then settle
  // ----------------------------------
  task automatic toggle(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clk_in);
      cap_pin_out <= ~cap_pin_out;
    end
    repeat (4) @(posedge clk_in);
  endtask : toggle
  // count pulses, width and spacing
  always @(posedge clk_in) begin
    cyc <= cyc + 16'h1;
    last <= cmp_pin_in;
    if (cmp_pin_in === 1'b1 && last === 1'b0) begin
      n_rise_out <= n_rise_out + 16'h1;
      gap_out <= cyc - t_rise;
      t_rise <= cyc;
    end
    if (cmp_pin_in === 1'b0 && last === 1'b1) begin
      width_out <= cyc - t_rise;
    end
  end
endmodule : pin_partner

// *** tb/timer_capture_and_pulse_compare_tb.sv ***
// self-checking bench for capture and pulse compare
`timescale 1ns/1ps
module timer_capture_and_pulse_compare_tb;
  import tcpc_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, cap_pin, cmp_pin, cap_irq, cmp_irq, wake;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic [1:0] ext_tick = 2'h0;
  logic [15:0] n_rise, width, gap;
  int num_errors = 0;
  int n_compared = 0;
  int n_wake = 0;
  int cnt;
  int exp_n[7] = '{0, 4, 4, 4, 1, 1, 0};
  logic [7:0] exp_st[7] = '{8'h0, 8'h19, 8'h1a, 8'h1b, 8'hc, 8'hd, 8'h6};
  always #20 clk_in = ~clk_in;
  // wake pulses seen
  always @(posedge clk_in) if (wake === 1'b1) n_wake++;
  timer_capture_and_pulse_compare dut (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .capture_input_pin_in(cap_pin), .cpu_idle_in(idle),
    .cpu_sleep_in(sleep), .tb_ext_tick_in(ext_tick), .compare_output_pin_out(cmp_pin),
    .capture_irq_out(cap_irq), .compare_irq_out(cmp_irq), .wake_out(wake));
  pin_partner u (.clk_in(clk_in), .cmp_pin_in(cmp_pin), .cap_pin_out(cap_pin),
    .n_rise_out(n_rise), .width_out(width), .gap_out(gap));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one ahb-lite single transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk(hresp, 32'h0);
  endtask : rdc
  // pop fifo until empty, each word checked
  task automatic drain(input logic [31:0] e);
    cnt = 0;
    bus(1'b0, OFF_CAP_CTRL, 32'h0);
    while (rd[CAP_BNE_BIT] === 1'b1 && cnt < 8) begin
      rdc(OFF_CAP_FIFO, e);
      cnt++;
      bus(1'b0, OFF_CAP_CTRL, 32'h0);
    end
  endtask : drain
  task automatic report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_in);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    rdc(OFF_CAP_CTRL, 32'h0);
    rdc(OFF_TB_PER, 32'hffff);
    rdc(8'h40, 32'h0);
    wr(OFF_TB_CNT, 32'h1234);
    wr(OFF_TB_CNT + TB_STRIDE, 32'h5678);
    // mode codes 0 to 6, timebases stopped
    for (int m = 0; m < 7; m++) begin
      wr(OFF_CAP_CTRL, m);
      u.toggle(m == 5 ? 32 : 10, 2);
      rdc(OFF_CAP_CTRL, exp_st[m]);
      drain(32'h1234);
      chk(cnt, exp_n[m]);
    end
    wr(OFF_CAP_CTRL, 32'h83);
    u.toggle(2, 2);
    drain(32'h5678);
    chk(cnt, 1);
    wr(OFF_CAP_CTRL, 32'h2003);
    idle <= 1'b1;
    u.toggle(2, 2);
    drain(32'h1234);
    chk(cnt, 0);
    idle <= 1'b0;
    u.toggle(2, 2);
    drain(32'h1234);
    chk(cnt, 1);
    wr(OFF_CAP_CTRL, 32'h7);
    sleep <= 1'b1;
    u.toggle(2, 3);
    chk(n_wake, 1);
    sleep <= 1'b0;
    wr(OFF_IRQ, 32'h4);
    wr(OFF_CAP_CTRL, 32'h43);
    u.toggle(4, 2);
    rdc(OFF_IRQ, 32'h0);
    u.toggle(2, 2);
    rdc(OFF_IRQ, 32'h4);
    chk(cap_irq, 1'b1);
    drain(32'h1234);
    wr(OFF_IRQ, 32'h4);
    wr(OFF_CAP_CTRL, 32'h61);
    u.toggle(1, 2);
    rdc(OFF_IRQ, 32'h4);
    drain(32'h1234);
    // single pulse on base a
    wr(OFF_TB_CNT, 32'h0);
    wr(OFF_TB_PER, 32'h14);
    wr(OFF_CMP_PRI, 32'h5);
    wr(OFF_CMP_SEC, 32'ha);
    wr(OFF_IRQ, 32'h6);
    wr(OFF_CMP_CTRL, CMP_SINGLE);
    wr(OFF_TB_CTRL, 32'h8000);
    repeat (70) @(posedge clk_in);
    chk(n_rise, 16'h1);
    chk(width, 16'h5);
    rdc(OFF_IRQ, 32'h3);
    chk(cmp_irq, 1'b1);
    wr(OFF_IRQ, 32'h3);
    wr(OFF_CMP_CTRL, CMP_SINGLE);
    repeat (70) @(posedge clk_in);
    chk(n_rise, 16'h2);
    // continuous pulses on base b
    wr(OFF_IRQ, 32'h3);
    wr(OFF_TB_CNT + TB_STRIDE, 32'h0);
    wr(OFF_TB_PER + TB_STRIDE, 32'h1e);
    wr(OFF_TB_CTRL + TB_STRIDE, 32'h8000);
    wr(OFF_CMP_CTRL, 32'hd);
    repeat (100) @(posedge clk_in);
    chk(gap, 16'h1f);
    chk(width, 16'h5);
    rdc(OFF_IRQ, 32'h3);
    wr(OFF_IRQ, 32'h3);
    repeat (40) @(posedge clk_in);
    rdc(OFF_IRQ, 32'h3);
    cnt = 0;
    while (cmp_pin !== 1'b1 && cnt < 100) begin
      @(posedge clk_in);
      cnt++;
    end
    chk(cmp_pin, 1'b1);
    wr(OFF_CMP_CTRL, 32'hc);
    @(posedge clk_in);
    chk(cmp_pin, 1'b0);
    // base a counts external ticks only
    wr(OFF_TB_CTRL, 32'h8002);
    wr(OFF_TB_CNT, 32'h0);
    ext_tick <= 2'h1;
    repeat (3) @(posedge clk_in);
    ext_tick <= 2'h0;
    rdc(OFF_TB_CNT, 32'h3);
    report_and_stop();
  end
endmodule : timer_capture_and_pulse_compare_tb
